/* File: hw/fcie_exec.sv */
// Implementation choices: the address map and register access over APB.
`timescale 1ns/100ps
module fcie_exec (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic issue_valid,
  output logic issue_ready,
  input wire fcie_pkg::fcie_issue_t issue,
  input wire logic [15:0] stack_top,
  output logic stack_push,
  output logic [15:0] stack_push_data,
  output logic stack_pop,
  output logic [15:0] pc,
  output logic [7:0] status,
  output logic done
);

  // ==========================================================
  // Helper functions
  // ==========================================================
  // Picks one bit of a byte; used by the skip and branch tests.
  function automatic logic pick_bit(input logic [7:0] value,
                                    input logic [2:0] sel);
    pick_bit = value[sel];
  endfunction

  // Tells whether an APB address names one of our registers.
  function automatic logic addr_mapped(input logic [7:0] addr);
    addr_mapped = (addr == fcie_pkg::REG_CTRL) ||
                  (addr == fcie_pkg::REG_STATUS) ||
                  (addr == fcie_pkg::REG_PC) ||
                  (addr == fcie_pkg::REG_INFO);
  endfunction

  // ==========================================================
  // Declarations
  // ==========================================================
  typedef enum logic {st_idle, st_exec} fcie_state_t;

  fcie_state_t state_ff; // Idle or working through extra cycles.
  logic [2:0] remain_ff; // Cycles left before the commit edge.
  logic [15:0] pc_ff; // Program counter.
  logic [7:0] status_ff; // Status register.
  logic enable_ff; // Software switch that lets issues in.
  logic [2:0] last_cyc_ff; // Cycle count of the last instruction.
  logic [15:0] pend_pc_ff; // Program counter held for the commit.
  logic [7:0] pend_status_ff; // Status held for the commit.
  logic pend_pop_ff; // The pending instruction pops the stack.
  logic push_ff; // One-cycle stack push strobe.
  logic [15:0] push_data_ff; // Return address being pushed.
  logic pop_ff; // One-cycle stack pop strobe.
  logic done_ff; // One-cycle completion strobe.
  logic [31:0] prdata_ff; // Read data captured in setup phase.

  logic accept; // An instruction is taken this cycle.
  logic commit_now; // Architectural state changes this edge.
  logic [15:0] nxt_pc; // Program counter the instruction leaves.
  logic [7:0] nxt_status; // Status the instruction leaves.
  logic [2:0] nxt_cycles; // Total cycles of the instruction.
  logic nxt_push; // Instruction pushes a return address.
  logic [15:0] nxt_push_data; // Address that a call pushes.
  logic nxt_pop; // Instruction pops the stack.
  logic [15:0] skip_pc; // Target of a taken skip.
  logic [2:0] skip_cycles; // Cycles of a taken skip.
  logic [15:0] branch_pc; // Target of a taken branch.
  logic [7:0] cmp_b; // Subtrahend for the compares.
  logic cmp_borrow; // Carry fed into the compare.
  fcie_pkg::fcie_sub_t cmp_flags; // Flags from the subtractor.
  logic [7:0] cmp_status; // Status with compare flags merged.
  logic commit_fast; // Single-cycle instruction commits at once.
  logic commit_slow; // Multi-cycle instruction commits now.
  logic wr_access; // APB write in its access phase.

  // ==========================================================
  // Compare datapath
  // ==========================================================
  // Only the immediate compare takes its subtrahend from the word.
  assign cmp_b = (issue.op == fcie_pkg::op_compare_immediate) ?
                 issue.imm : issue.rr_val;
  // Only the carry compare folds in the old carry.
  assign cmp_borrow = (issue.op == fcie_pkg::op_compare_with_carry) &
                      status_ff[fcie_pkg::FLAG_C];

  fcie_sub_flags u_sub (
    .a(issue.rd_val),
    .b(cmp_b),
    .borrow_in(cmp_borrow),
    .chain_zero(status_ff[fcie_pkg::FLAG_Z]),
    .keep_zero(issue.op == fcie_pkg::op_compare_with_carry),
    .flags(cmp_flags)
  );

  // Merges the five compare flags; the other bits stay as they are.
  always_comb begin
    cmp_status = status_ff;
    cmp_status[fcie_pkg::FLAG_Z] = cmp_flags.z;
    cmp_status[fcie_pkg::FLAG_N] = cmp_flags.n;
    cmp_status[fcie_pkg::FLAG_V] = cmp_flags.v;
    cmp_status[fcie_pkg::FLAG_C] = cmp_flags.c;
    cmp_status[fcie_pkg::FLAG_H] = cmp_flags.h;
  end

  // ==========================================================
  // Skip and branch targets
  // ==========================================================
  // A two-word follower costs one more word and one more cycle.
  assign skip_pc = pc_ff + (issue.follow_two_word ?
                   fcie_pkg::PC_STEP_THREE :
                   fcie_pkg::PC_STEP_TWO);
  assign skip_cycles = issue.follow_two_word ? fcie_pkg::CYC_THREE :
                       fcie_pkg::CYC_TWO;
  // The offset is sign extended; the step of one is added on top.
  assign branch_pc = pc_ff + {{9{issue.offset[6]}}, issue.offset} +
                     fcie_pkg::PC_STEP_ONE;

  // ==========================================================
  // Instruction decode
  // ==========================================================
  // Works out where the instruction leaves the machine; every path
  // starts from "fall through, one cycle, flags untouched".
  always_comb begin
    nxt_pc = pc_ff + fcie_pkg::PC_STEP_ONE;
    nxt_status = status_ff;
    nxt_cycles = fcie_pkg::CYC_ONE;
    nxt_push = 1'b0;
    nxt_push_data = pc_ff + fcie_pkg::PC_STEP_ONE;
    nxt_pop = 1'b0;
    unique case (issue.op)
      fcie_pkg::op_pointer_call: begin
        // One-word call returns to the following word.
        nxt_push = 1'b1;
        nxt_pc = issue.z_ptr;
        nxt_cycles = fcie_pkg::CYC_THREE;
      end
      fcie_pkg::op_absolute_call: begin
        // The target occupies a second word, so return past it.
        nxt_push = 1'b1;
        nxt_push_data = pc_ff + fcie_pkg::PC_STEP_TWO;
        nxt_pc = issue.target;
        nxt_cycles = fcie_pkg::CYC_FOUR;
      end
      fcie_pkg::op_subroutine_return: begin
        nxt_pop = 1'b1;
        nxt_pc = stack_top;
        nxt_cycles = fcie_pkg::CYC_FOUR;
      end
      fcie_pkg::op_interrupt_return: begin
        nxt_pop = 1'b1;
        nxt_pc = stack_top;
        nxt_cycles = fcie_pkg::CYC_FOUR;
        nxt_status[fcie_pkg::FLAG_I] = 1'b1;
      end
      fcie_pkg::op_compare_skip_equal: begin
        if (issue.rd_val == issue.rr_val) begin
          nxt_pc = skip_pc;
          nxt_cycles = skip_cycles;
        end
      end
      fcie_pkg::op_register_compare: begin
        nxt_status = cmp_status;
      end
      fcie_pkg::op_compare_with_carry: begin
        nxt_status = cmp_status;
      end
      fcie_pkg::op_compare_immediate: begin
        nxt_status = cmp_status;
      end
      fcie_pkg::op_skip_reg_bit_clear: begin
        if (!pick_bit(issue.rr_val, issue.bit_sel)) begin
          nxt_pc = skip_pc;
          nxt_cycles = skip_cycles;
        end
      end
      fcie_pkg::op_skip_reg_bit_set: begin
        if (pick_bit(issue.rr_val, issue.bit_sel)) begin
          nxt_pc = skip_pc;
          nxt_cycles = skip_cycles;
        end
      end
      fcie_pkg::op_skip_io_bit_clear: begin
        if (!pick_bit(issue.io_val, issue.bit_sel)) begin
          nxt_pc = skip_pc;
          nxt_cycles = skip_cycles;
        end
      end
      fcie_pkg::op_skip_io_bit_set: begin
        if (pick_bit(issue.io_val, issue.bit_sel)) begin
          nxt_pc = skip_pc;
          nxt_cycles = skip_cycles;
        end
      end
      fcie_pkg::op_branch_flag_set: begin
        if (pick_bit(status_ff, issue.bit_sel)) begin
          nxt_pc = branch_pc;
          nxt_cycles = fcie_pkg::CYC_TWO;
        end
      end
      fcie_pkg::op_branch_flag_clear: begin
        if (!pick_bit(status_ff, issue.bit_sel)) begin
          nxt_pc = branch_pc;
          nxt_cycles = fcie_pkg::CYC_TWO;
        end
      end
      fcie_pkg::op_branch_not_equal: begin
        if (!status_ff[fcie_pkg::FLAG_Z]) begin
          nxt_pc = branch_pc;
          nxt_cycles = fcie_pkg::CYC_TWO;
        end
      end
      fcie_pkg::op_branch_carry_clear: begin
        if (!status_ff[fcie_pkg::FLAG_C]) begin
          nxt_pc = branch_pc;
          nxt_cycles = fcie_pkg::CYC_TWO;
        end
      end
    endcase
  end

  // ==========================================================
  // Issue handshake and sequencing
  // ==========================================================
  // The unit takes one instruction at a time and only when enabled.
  assign issue_ready = (state_ff == st_idle) & enable_ff;
  assign accept = issue_valid & issue_ready;
  assign commit_fast = accept & (nxt_cycles == fcie_pkg::CYC_ONE);
  assign commit_slow = (state_ff == st_exec) & (remain_ff == 3'h1);
  assign commit_now = commit_fast | commit_slow;

  // Counts the extra cycles; the commit lands on the last one.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= st_idle;
      remain_ff <= 3'h0;
    end else begin
      unique case (state_ff)
        st_idle: begin
          if (accept && nxt_cycles != fcie_pkg::CYC_ONE) begin
            state_ff <= st_exec;
            remain_ff <= nxt_cycles - fcie_pkg::CYC_ONE;
          end
        end
        st_exec: begin
          remain_ff <= remain_ff - 3'h1;
          if (remain_ff == 3'h1) begin
            state_ff <= st_idle;
          end
        end
      endcase
    end
  end

  // Holds the results of a multi-cycle instruction until commit.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_pc_ff <= fcie_pkg::PC_RESET;
      pend_status_ff <= fcie_pkg::STATUS_RESET;
      pend_pop_ff <= 1'b0;
      last_cyc_ff <= 3'h0;
    end else if (accept) begin
      pend_pc_ff <= nxt_pc;
      pend_status_ff <= nxt_status;
      pend_pop_ff <= nxt_pop;
      last_cyc_ff <= nxt_cycles;
    end
  end

  // ==========================================================
  // Stack strobes and completion
  // ==========================================================
  // Push goes out right after accept, so the stack holds the return
  // address before the call's new program counter is visible.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      push_ff <= 1'b0;
      push_data_ff <= 16'h0000;
    end else begin
      push_ff <= accept & nxt_push;
      if (accept && nxt_push) begin
        push_data_ff <= nxt_push_data;
      end
    end
  end

  // Pop and done are strobed for the one cycle after the commit.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pop_ff <= 1'b0;
      done_ff <= 1'b0;
    end else begin
      pop_ff <= commit_slow & pend_pop_ff;
      done_ff <= commit_now;
    end
  end

  // ==========================================================
  // Architectural state
  // ==========================================================
  assign wr_access = psel & penable & pwrite;

  // Program counter: the instruction's commit beats a software
  // write, and software may only move it while the unit is idle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pc_ff <= fcie_pkg::PC_RESET;
    end else if (commit_fast) begin
      pc_ff <= nxt_pc;
    end else if (commit_slow) begin
      pc_ff <= pend_pc_ff;
    end else if (wr_access && paddr == fcie_pkg::REG_PC &&
                 state_ff == st_idle) begin
      pc_ff <= pwdata[15:0];
    end
  end

  // Status: hardware updates win over a software write in the same
  // cycle so that no flag change is lost.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_ff <= fcie_pkg::STATUS_RESET;
    end else if (commit_fast) begin
      status_ff <= nxt_status;
    end else if (commit_slow) begin
      status_ff <= pend_status_ff;
    end else if (wr_access && paddr == fcie_pkg::REG_STATUS) begin
      status_ff <= pwdata[7:0];
    end
  end

  // Control register: the enable bit gates new issues.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enable_ff <= fcie_pkg::CTRL_ENABLE_RESET;
    end else if (wr_access && paddr == fcie_pkg::REG_CTRL) begin
      enable_ff <= pwdata[fcie_pkg::CTRL_ENABLE_BIT];
    end
  end

  // ==========================================================
  // APB read path
  // ==========================================================
  // Read data is captured in the setup phase so that it comes from a
  // flip-flop while pready is already high in the access phase. A
  // value that changes between setup and access reads as it was at
  // setup; that one-cycle lag is the price of a zero-wait slave.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= 32'h00000000;
    end else if (psel && !penable) begin
      prdata_ff <= 32'h00000000;
      if (paddr == fcie_pkg::REG_CTRL) begin
        prdata_ff[fcie_pkg::CTRL_ENABLE_BIT] <= enable_ff;
      end else if (paddr == fcie_pkg::REG_STATUS) begin
        prdata_ff[7:0] <= status_ff;
      end else if (paddr == fcie_pkg::REG_PC) begin
        prdata_ff[15:0] <= pc_ff;
      end else if (paddr == fcie_pkg::REG_INFO) begin
        prdata_ff[fcie_pkg::INFO_BUSY_BIT] <= (state_ff == st_exec);
        prdata_ff[fcie_pkg::INFO_CYC_MSB:fcie_pkg::INFO_CYC_LSB] <=
          last_cyc_ff;
      end
    end
  end

  // ==========================================================
  // Outputs
  // ==========================================================
  assign prdata = prdata_ff;
  assign pready = 1'b1;
  // Unmapped addresses answer with an error and change nothing.
  assign pslverr = psel & penable & ~addr_mapped(paddr);
  assign stack_push = push_ff;
  assign stack_push_data = push_data_ff;
  assign stack_pop = pop_ff;
  assign pc = pc_ff;
  assign status = status_ff;
  assign done = done_ff;

endmodule

/* File: hw/fcie_pkg.sv */
package fcie_pkg;

  // ==========================================================
  // Register map (APB byte addresses, one aligned word each)
  // ==========================================================
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_PC = 8'h08;
  localparam logic [7:0] REG_INFO = 8'h0c;

  // Control bit that lets the unit accept instructions.
  localparam int unsigned CTRL_ENABLE_BIT = 0;
  localparam logic CTRL_ENABLE_RESET = 1'b1;

  // Info register fields: busy flag and last instruction cycles.
  localparam int unsigned INFO_BUSY_BIT = 0;
  localparam int unsigned INFO_CYC_LSB = 4;
  localparam int unsigned INFO_CYC_MSB = 6;

  // Reset values of the architectural state.
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [15:0] PC_RESET = 16'h0000;

  // ==========================================================
  // Status register bit positions
  // ==========================================================
  localparam int unsigned FLAG_C = 0;
  localparam int unsigned FLAG_Z = 1;
  localparam int unsigned FLAG_N = 2;
  localparam int unsigned FLAG_V = 3;
  localparam int unsigned FLAG_H = 5;
  localparam int unsigned FLAG_I = 7;

  // ==========================================================
  // Cycle counts and program counter steps
  // ==========================================================
  localparam logic [2:0] CYC_ONE = 3'h1;
  localparam logic [2:0] CYC_TWO = 3'h2;
  localparam logic [2:0] CYC_THREE = 3'h3;
  localparam logic [2:0] CYC_FOUR = 3'h4;
  localparam logic [15:0] PC_STEP_ONE = 16'h0001;
  localparam logic [15:0] PC_STEP_TWO = 16'h0002;
  localparam logic [15:0] PC_STEP_THREE = 16'h0003;

  // ==========================================================
  // Operation kinds handed over by the fetch path
  // ==========================================================
  typedef enum logic [3:0] {
    op_pointer_call,
    op_absolute_call,
    op_subroutine_return,
    op_interrupt_return,
    op_compare_skip_equal,
    op_register_compare,
    op_compare_with_carry,
    op_compare_immediate,
    op_skip_reg_bit_clear,
    op_skip_reg_bit_set,
    op_skip_io_bit_clear,
    op_skip_io_bit_set,
    op_branch_flag_set,
    op_branch_flag_clear,
    op_branch_not_equal,
    op_branch_carry_clear
  } fcie_op_t;

  // One issued instruction with its operands already read.
  typedef struct packed {
    fcie_op_t op;
    logic [7:0] rd_val;
    logic [7:0] rr_val;
    logic [7:0] imm;
    logic [7:0] io_val;
    logic [2:0] bit_sel;
    logic [6:0] offset;
    logic [15:0] target;
    logic [15:0] z_ptr;
    logic follow_two_word;
  } fcie_issue_t;

  // Flags produced by a compare.
  typedef struct packed {
    logic z;
    logic n;
    logic v;
    logic c;
    logic h;
  } fcie_sub_t;

endpackage

/* File: hw/fcie_sub_flags.sv */
`timescale 1ns/100ps
module fcie_sub_flags (
  input wire logic [7:0] a,
  input wire logic [7:0] b,
  input wire logic borrow_in,
  input wire logic chain_zero,
  input wire logic keep_zero,
  output fcie_pkg::fcie_sub_t flags
);

  // ==========================================================
  // Difference without storing a result
  // ==========================================================
  logic [7:0] diff; // Difference that only feeds the flags.

  // The width stays at eight bits; carry comes from the bit terms.
  assign diff = a - b - {7'h00, borrow_in};

  // ==========================================================
  // Flag terms
  // ==========================================================
  // Borrow out of bit 3 and bit 7 follow the usual subtract terms.
  always_comb begin
    flags.h = (~a[3] & b[3]) | (b[3] & diff[3]) | (diff[3] & ~a[3]);
    flags.c = (~a[7] & b[7]) | (b[7] & diff[7]) | (diff[7] & ~a[7]);
    flags.v = (a[7] & ~b[7] & ~diff[7]) | (~a[7] & b[7] & diff[7]);
    flags.n = diff[7];
    // A chained compare may only keep a zero, never create one, so
    // multi-byte compares give a zero flag for the whole value.
    if (keep_zero) begin
      flags.z = (diff == 8'h00) & chain_zero;
    end else begin
      flags.z = (diff == 8'h00);
    end
  end

endmodule

/* File: verification/fcie_exec_props.sv */
`timescale 1ns/100ps
// ==========================================================
// Timing and result checks at the issue and stack ports
// ==========================================================
module fcie_exec_props (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic issue_valid,
  input wire logic issue_ready,
  input wire fcie_pkg::fcie_issue_t issue,
  input wire logic [15:0] stack_top,
  input wire logic stack_push,
  input wire logic [15:0] stack_push_data,
  input wire logic stack_pop,
  input wire logic [15:0] pc,
  input wire logic [7:0] status,
  input wire logic done
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  // An instruction of the given kind is accepted at this edge.
  sequence acc_s(fcie_pkg::fcie_op_t o);
    issue_valid && issue_ready && issue.op == o;
  endsequence

  pcall_commit_a: assert property (
    acc_s(fcie_pkg::op_pointer_call) |-> ##3
    done && pc == $past(issue.z_ptr, 3)) else $error("pointer call late");
  acall_commit_a: assert property (
    acc_s(fcie_pkg::op_absolute_call) |-> ##4
    done && pc == $past(issue.target, 4)) else $error("call late");
  call_push_a: assert property (
    acc_s(fcie_pkg::op_absolute_call) |=>
    stack_push && stack_push_data == $past(pc) + 16'h0002)
    else $error("bad pushed address");
  ret_pop_a: assert property (
    acc_s(fcie_pkg::op_subroutine_return) |-> ##4
    done && stack_pop && pc == $past(stack_top, 4)) else $error("bad return");
  interrupt_return_enable_a: assert property (
    acc_s(fcie_pkg::op_interrupt_return) |-> ##4
    status[fcie_pkg::FLAG_I]) else $error("enable flag not set");
  cmp_flags_a: assert property (
    acc_s(fcie_pkg::op_register_compare) |=>
    done && status[fcie_pkg::FLAG_C] == ($past(issue.rd_val) <
    $past(issue.rr_val))) else $error("compare carry wrong");
  cpc_carry_a: assert property (
    acc_s(fcie_pkg::op_compare_with_carry) |=>
    status[fcie_pkg::FLAG_C] == ({1'b0, $past(issue.rd_val)} <
    {1'b0, $past(issue.rr_val)} + 9'($past(status[fcie_pkg::FLAG_C]))))
    else $error("carry compare wrong");
  cpi_zero_a: assert property (
    acc_s(fcie_pkg::op_compare_immediate) |=>
    status[fcie_pkg::FLAG_Z] == ($past(issue.rd_val) == $past(issue.imm)))
    else $error("immediate compare wrong");
  bne_fall_a: assert property (
    acc_s(fcie_pkg::op_branch_not_equal) ##0 status[fcie_pkg::FLAG_Z]
    |=> done && pc == $past(pc) + 16'h0001 && $stable(status))
    else $error("branch taken on zero");
  skip_two_a: assert property (
    acc_s(fcie_pkg::op_skip_reg_bit_set) ##0
    issue.rr_val[issue.bit_sel] && issue.follow_two_word |-> ##3
    done && pc == $past(pc, 3) + 16'h0003) else $error("skip length wrong");
endmodule

bind fcie_exec fcie_exec_props u_props (.pclk(pclk), .presetn(presetn),
  .issue_valid(issue_valid), .issue_ready(issue_ready), .issue(issue),
  .stack_top(stack_top), .stack_push(stack_push),
  .stack_push_data(stack_push_data), .stack_pop(stack_pop), .pc(pc),
  .status(status), .done(done));

/* File: verification/fcie_stack_model.sv */
`timescale 1ns/100ps
// ==========================================================
// Return stack beside the execution unit
// ==========================================================
module fcie_stack_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic stack_push,
  input wire logic [15:0] stack_push_data,
  input wire logic stack_pop,
  output logic [15:0] stack_top
);
  logic [15:0] mem_ff [8]; // Eight entries are plenty for the nesting used.
  logic [2:0] sp_ff; // Points at the next free entry.

  // An empty stack shows an inverted pattern, so a stray pop is not silent.
  assign stack_top = (sp_ff == 3'h0) ? ~mem_ff[0] : mem_ff[sp_ff - 3'h1];

  // Pushes store the return address and pops discard the top entry.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sp_ff <= 3'h0;
    end else if (stack_push) begin
      mem_ff[sp_ff] <= stack_push_data;
      sp_ff <= sp_ff + 3'h1;
    end else if (stack_pop) begin
      sp_ff <= sp_ff - 3'h1;
    end
  end
endmodule

/* File: verification/flow_compare_instr_exec_bench.sv */
`timescale 1ns/100ps
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin n_errors++; \
  $display("ERROR %s exp %h got %h", n, e, g); end end
module flow_compare_instr_exec_bench;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr, status;
  logic [31:0] pwdata, prdata, q;
  logic issue_valid, issue_ready, stack_push, stack_pop, done;
  logic [15:0] stack_top, stack_push_data, pc;
  fcie_pkg::fcie_issue_t issue;
  int n_errors = 0, compares = 0, cycles = 0;

  fcie_exec u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .issue_valid(issue_valid), .issue_ready(issue_ready), .issue(issue),
    .stack_top(stack_top), .stack_push(stack_push),
    .stack_push_data(stack_push_data), .stack_pop(stack_pop), .pc(pc),
    .status(status), .done(done));
  fcie_stack_model u_stack (.pclk(pclk), .presetn(presetn),
    .stack_push(stack_push), .stack_push_data(stack_push_data),
    .stack_pop(stack_pop), .stack_top(stack_top));

  // ==========================================================
  // Clock, watchdog and verdict
  // ==========================================================
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  // The whole run needs well under a thousand cycles.
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 5000) begin
      n_errors++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // ==========================================================
  // APB master: one idle edge first, so no signal is set twice at once.
  // ==========================================================
  task automatic apb(input logic wr, input logic [7:0] a,
    input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // A write lands on the edge above, so let it settle before checks.
    @(posedge pclk);
  endtask

  // ==========================================================
  // Issue one instruction, then count edges from accept to done.
  // ==========================================================
  task automatic step(input fcie_pkg::fcie_op_t o, input logic [7:0] rd,
    input logic [7:0] rr, input logic [15:0] x, input logic [2:0] s,
    input logic [6:0] k, input logic tw, input int cyc,
    input logic [15:0] epc, input logic [7:0] est);
    fcie_pkg::fcie_issue_t p;
    int n;
    p = '0;
    p.op = o;
    p.rd_val = rd;
    p.rr_val = rr;
    p.imm = x[7:0];
    p.io_val = x[7:0];
    p.target = x;
    p.z_ptr = x;
    p.bit_sel = s;
    p.offset = k;
    p.follow_two_word = tw;
    n = 0;
    @(posedge pclk);
    issue <= p;
    issue_valid <= 1'b1;
    do begin @(posedge pclk); n++; end while (issue_ready !== 1'b1 && n < 20);
    issue_valid <= 1'b0;
    n = 0;
    do begin @(posedge pclk); n++; end while (done !== 1'b1 && n < 20);
    `CHK("cycles", cyc, n)
    `CHK("pc", epc, pc)
    `CHK("status", est, status)
  endtask

  // ==========================================================
  // Main sequence
  // ==========================================================
  initial begin
    {presetn, psel, penable, pwrite, issue_valid} = '0;
    paddr = 8'h00;
    pwdata = 32'h0;
    issue = '0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 8'h00, 32'h0);
    `CHK("ctrl", 32'h00000001, q)
    apb(1'b0, 8'h10, 32'h0);
    `CHK("unmapped", 1'b1, err)
    apb(1'b1, 8'h00, 32'h0);
    `CHK("disabled", 1'b0, issue_ready)
    apb(1'b1, 8'h00, 32'h1);
    apb(1'b1, 8'h08, 32'h0100);
    `CHK("pc write", 16'h0100, pc)
    step(fcie_pkg::op_absolute_call,
      0, 0, 16'h0200, 0, 0, 0, 4, 16'h0200, 8'h00);
    apb(1'b1, 8'h0c, 32'hff);
    apb(1'b0, 8'h0c, 32'h0);
    `CHK("info", 32'h00000040, q)
    step(fcie_pkg::op_pointer_call,
      0, 0, 16'h0300, 0, 0, 0, 3, 16'h0300, 8'h00);
    step(fcie_pkg::op_subroutine_return,
      0, 0, 0, 0, 0, 0, 4, 16'h0201, 8'h00);
    step(fcie_pkg::op_interrupt_return,
      0, 0, 0, 0, 0, 0, 4, 16'h0102, 8'h80);
    step(fcie_pkg::op_register_compare,
      3, 5, 0, 0, 0, 0, 1, 16'h0103, 8'ha5);
    step(fcie_pkg::op_compare_immediate,
      5, 0, 5, 0, 0, 0, 1, 16'h0104, 8'h82);
    step(fcie_pkg::op_branch_not_equal,
      0, 0, 0, 0, 7'h7e, 0, 1, 16'h0105, 8'h82);
    step(fcie_pkg::op_compare_with_carry,
      5, 4, 0, 0, 0, 0, 1, 16'h0106, 8'h80);
    step(fcie_pkg::op_branch_not_equal,
      0, 0, 0, 0, 7'h7e, 0, 2, 16'h0105, 8'h80);
    step(fcie_pkg::op_skip_reg_bit_set,
      0, 8'h80, 0, 7, 0, 1, 3, 16'h0108, 8'h80);
    step(fcie_pkg::op_skip_reg_bit_clear,
      0, 8'h01, 0, 0, 0, 0, 1, 16'h0109, 8'h80);
    step(fcie_pkg::op_skip_io_bit_clear,
      0, 0, 16'hfe, 0, 0, 0, 2, 16'h010b, 8'h80);
    step(fcie_pkg::op_skip_io_bit_set,
      0, 0, 16'h04, 2, 0, 1, 3, 16'h010e, 8'h80);
    step(fcie_pkg::op_compare_skip_equal,
      7, 6, 0, 0, 0, 0, 1, 16'h010f, 8'h80);
    step(fcie_pkg::op_compare_skip_equal,
      6, 6, 0, 0, 0, 0, 2, 16'h0111, 8'h80);
    step(fcie_pkg::op_branch_carry_clear,
      0, 0, 0, 0, 7'h03, 0, 2, 16'h0115, 8'h80);
    step(fcie_pkg::op_branch_flag_set,
      0, 0, 0, 7, 7'h01, 0, 2, 16'h0117, 8'h80);
    step(fcie_pkg::op_branch_flag_clear,
      0, 0, 0, 0, 7'h7d, 0, 2, 16'h0115, 8'h80);
    print_verdict();
  end
endmodule
